/* File: hdl/scan_seq_regs.svh */
`ifndef SCAN_SEQ_REGS_SVH
`define SCAN_SEQ_REGS_SVH

// Register offsets (byte addresses)
`define CTRL_OFS     8'h00
`define CMD_OFS      8'h04
`define CHEN_OFS     8'h08
`define DIV_OFS      8'h0C
`define STAT_OFS     8'h10
`define MASK_OFS     8'h14
`define RES_OFS      8'h20
`define RES_LAST_OFS 8'h40

// Control fields
`define CTRL_EN      0
`define CTRL_HWTRIG  1
`define CTRL_EXTCLK  2
`define CTRL_RES_LO  3
`define CTRL_RES_HI  4
`define CTRL_W       5

// Command fields
`define CMD_START    0
`define CMD_STOP     1

// Channel enable fields
`define CHEN_INJ     8
`define CHEN_W       9

// Status and mask fields
`define STAT_SCAN    0
`define STAT_BUSY    1

// Reset values
`define CTRL_RST     5'h00
`define CHEN_RST     9'h001
`define DIV_RST      8'h03
`define STAT_RST     1'h0
`define MASK_RST     1'h0

// Conversion timing in conversion clocks, and channel numbers
`define SAMPLE_CLKS  5'h04
`define CONV_EXTRA   5'h02
`define NO_CHAN      4'h9
`define INJ_CHAN     4'h8

// Host timing
`define CLK_MHZ      40
`define SETTLE_NS    10000
`define SETTLE_CYC   ((`SETTLE_NS * `CLK_MHZ + 999) / 1000)
`define TRIG_HIGH    2'h2
`define EXT_DIV_RST  8'h03

`endif

/* File: hdl/scan_seq_pkg.sv */
package scan_seq_pkg;

    typedef enum logic [1:0] {
        SEQ_IDLE    = 2'b00,
        SEQ_SAMPLE  = 2'b01,
        SEQ_CONVERT = 2'b10
    } seq_state_t;

    typedef enum logic [1:0] {
        RES_12 = 2'b00,
        RES_10 = 2'b01,
        RES_8  = 2'b10
    } res_sel_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic       extPrev;
        logic       tick;
    } tick_state_t;

    typedef struct packed {
        seq_state_t        st;
        logic [3:0]        chan;
        logic [4:0]        cnt;
        logic [4:0]        ctrl;
        logic [8:0]        chEn;
        logic [7:0]        div;
        logic              status;
        logic              mask;
        logic              pend;
        logic              trigPrev;
        logic              sampleDone;
        logic              scanComplete;
        logic              irq;
        logic [31:0]       rdData;
        logic [8:0][11:0]  res;
    } dev_state_t;

    typedef struct packed {
        logic [9:0] settleCnt;
        logic       settled;
        logic       trigHold;
        logic [1:0] trigCnt;
        logic       scanTrig;
        logic [7:0] divCnt;
        logic       extClk;
        logic       sdPrev;
        logic       scPrev;
        logic       muxFree;
        logic [3:0] muxSel;
        logic       scanDone;
    } host_state_t;

endpackage

/* File: hdl/scan_seq_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface scan_seq_if;
    logic       scanTrig;
    logic       extConvClk;
    logic       sampleDone;
    logic       scanComplete;
    logic [3:0] chanSel;

    modport dev (
        input  scanTrig,
        input  extConvClk,
        output sampleDone,
        output scanComplete,
        output chanSel
    );

    modport ext (
        output scanTrig,
        output extConvClk,
        input  sampleDone,
        input  scanComplete,
        input  chanSel
    );
endinterface

`default_nettype wire

/* File: hdl/conv_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none

module conv_tick_gen #(
    parameter int DW = 8
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          useExt,
    input  wire logic [DW-1:0] divisor,
    input  wire logic          extClk,
    output logic               tick
);
    scan_seq_pkg::tick_state_t s;
    scan_seq_pkg::tick_state_t n;

    always_comb begin
        n = s;
        n.extPrev = extClk;
        n.tick = 1'b0;
        if (useExt) begin
            // Pin is sampled, so it must run below half of clk
            n.tick = extClk & ~s.extPrev;
            n.cnt = 8'h00;
        end else if (s.cnt >= 8'(divisor)) begin
            n.cnt = 8'h00;
            n.tick = 1'b1;
        end else begin
            n.cnt = s.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tick = s.tick;
endmodule

`default_nettype wire

/* File: hdl/scan_seq_device.sv */
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "scan_seq_regs.svh"

// Summary of operation
// - Trigger rising edge starts one scan
// - First trigger edge 10 us after start
// - Sample done high one conversion clock
// - Mux may switch after sampling ends
// - Scan complete rises when results readable
// - Scan complete drives interrupt and pin
// - Free running scans until stop command
// - Firmware start command starts one scan
// - Up to eight channels, own results
// - Injection channel enabled by firmware
// - Resolution selectable 8, 10, 12 bits
// - Up to 1 Msps at 12 bits
// - Internal conversion clock 1 to 18 MHz
// - Unbypassed reference limits clock 3 MHz
// - External source uses clock input pin
module scan_seq_device #(
    parameter int DIV_W = 8
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    scan_seq_if.dev          io,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    output logic      [31:0] regRdData,
    output logic             irq,
    input  wire logic [11:0] convData
);
    scan_seq_pkg::dev_state_t s;
    scan_seq_pkg::dev_state_t n;

    logic       tick;
    logic       enabled;
    logic       hwMode;
    logic       wrChen;
    logic [3:0] firstChan;
    logic [3:0] nextChan;
    logic [4:0] convLast;
    logic [3:0] rdIdx;
    scan_seq_pkg::res_sel_t resSel;

    function automatic logic [3:0] pick_chan(input logic [8:0] m, input logic [3:0] from);
        logic [3:0] r;
        r = `NO_CHAN;
        for (int i = 8; i >= 0; i--) begin
            if (m[i] && (4'(i) >= from)) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // Conversion clock from divider or pin
    conv_tick_gen #(
        .DW(DIV_W)
    ) u_conv_tick_gen (
        .clk    (clk),
        .rst_n  (rst_n),
        .useExt (s.ctrl[`CTRL_EXTCLK]),
        .divisor(DIV_W'(s.div)),
        .extClk (io.extConvClk),
        .tick   (tick)
    );

    assign enabled   = s.ctrl[`CTRL_EN];
    assign hwMode    = s.ctrl[`CTRL_HWTRIG];
    assign resSel    = scan_seq_pkg::res_sel_t'(s.ctrl[`CTRL_RES_HI:`CTRL_RES_LO]);
    assign wrChen    = regWrEn && (regAddr == `CHEN_OFS);
    assign firstChan = pick_chan(s.chEn, 4'h0);
    assign nextChan  = pick_chan(s.chEn, s.chan + 4'h1);
    assign rdIdx     = 4'((regAddr - `RES_OFS) >> 2);

    // Bit cycle count follows resolution
    always_comb begin
        case (resSel)
            scan_seq_pkg::RES_10: convLast = 5'h0A + `CONV_EXTRA - 5'h01;
            scan_seq_pkg::RES_8:  convLast = 5'h08 + `CONV_EXTRA - 5'h01;
            default:              convLast = 5'h0C + `CONV_EXTRA - 5'h01;
        endcase
    end

    always_comb begin
        n = s;

        // Register writes
        if (regWrEn) begin
            case (regAddr)
                `CTRL_OFS: begin
                    n.ctrl = regWrData[`CTRL_W-1:0];
                end
                `CMD_OFS: begin
                    if (regWrData[`CMD_START] && hwMode) begin
                        n.pend = 1'b1;
                    end
                    if (regWrData[`CMD_STOP]) begin
                        n.ctrl[`CTRL_EN] = 1'b0;
                    end
                end
                `CHEN_OFS: begin
                    n.chEn = regWrData[`CHEN_W-1:0];
                end
                `DIV_OFS: begin
                    n.div = regWrData[7:0];
                end
                `STAT_OFS: begin
                    n.status = s.status & ~regWrData[`STAT_SCAN];
                end
                `MASK_OFS: begin
                    n.mask = regWrData[`STAT_SCAN];
                end
                default: begin
                end
            endcase
        end

        // Read data stands one cycle only
        n.rdData = 32'h0000_0000;
        if (regRdEn) begin
            case (regAddr)
                `CTRL_OFS: n.rdData = 32'(s.ctrl);
                `CHEN_OFS: n.rdData = 32'(s.chEn);
                `DIV_OFS:  n.rdData = 32'(s.div);
                `STAT_OFS: n.rdData = 32'({s.st != scan_seq_pkg::SEQ_IDLE, s.status});
                `MASK_OFS: n.rdData = 32'(s.mask);
                default: begin
                    if (regAddr >= `RES_OFS && regAddr <= `RES_LAST_OFS && regAddr[1:0] == 2'h0) begin
                        n.rdData = 32'(s.res[rdIdx]);
                    end
                end
            endcase
        end

        // Trigger edge, latched once while busy
        n.trigPrev = io.scanTrig;
        if (io.scanTrig && !s.trigPrev && hwMode && enabled) begin
            n.pend = 1'b1;
        end
        if (!enabled || !hwMode) begin
            n.pend = 1'b0;
        end

        if (tick) begin
            n.sampleDone   = 1'b0;
            n.scanComplete = 1'b0;
            case (s.st)
                scan_seq_pkg::SEQ_IDLE: begin
                    if (enabled && (hwMode ? s.pend : 1'b1) && firstChan != `NO_CHAN) begin
                        n.pend = 1'b0;
                        n.chan = firstChan;
                        n.cnt  = 5'h00;
                        n.st   = scan_seq_pkg::SEQ_SAMPLE;
                    end
                end
                scan_seq_pkg::SEQ_SAMPLE: begin
                    n.cnt = s.cnt + 5'h01;
                    if (s.cnt == `SAMPLE_CLKS - 5'h01) begin
                        // Input no longer needed, mux is free
                        n.sampleDone = 1'b1;
                        n.cnt = 5'h00;
                        n.st  = scan_seq_pkg::SEQ_CONVERT;
                    end
                end
                scan_seq_pkg::SEQ_CONVERT: begin
                    n.cnt = s.cnt + 5'h01;
                    if (s.cnt == convLast) begin
                        case (resSel)
                            scan_seq_pkg::RES_10: n.res[s.chan] = {2'h0, convData[11:2]};
                            scan_seq_pkg::RES_8:  n.res[s.chan] = {4'h0, convData[11:4]};
                            default:              n.res[s.chan] = convData;
                        endcase
                        // Injection is one-shot; a new enable wins
                        if (s.chan == `INJ_CHAN && !wrChen) begin
                            n.chEn[`CHEN_INJ] = 1'b0;
                        end
                        n.cnt = 5'h00;
                        if (nextChan != `NO_CHAN) begin
                            n.chan = nextChan;
                            n.st   = scan_seq_pkg::SEQ_SAMPLE;
                        end else begin
                            // Result already in array at this edge
                            n.scanComplete = 1'b1;
                            n.status = 1'b1;
                            n.st = scan_seq_pkg::SEQ_IDLE;
                        end
                    end
                end
                default: begin
                    n.st = scan_seq_pkg::SEQ_IDLE;
                end
            endcase
        end

        n.irq = n.status & n.mask;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s        <= '0;
            s.ctrl   <= `CTRL_RST;
            s.chEn   <= `CHEN_RST;
            s.div    <= `DIV_RST;
            s.status <= `STAT_RST;
            s.mask   <= `MASK_RST;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from state flops
    assign io.sampleDone   = s.sampleDone;
    assign io.scanComplete = s.scanComplete;
    assign io.chanSel      = s.chan;
    assign regRdData       = s.rdData;
    assign irq             = s.irq;
endmodule

`default_nettype wire

/* File: hdl/scan_seq_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scan_seq_regs.svh"

module scan_seq_host #(
    parameter logic [7:0] EXT_DIV = `EXT_DIV_RST,
    parameter int         SETTLE  = `SETTLE_CYC
) (
    input  wire logic  clk,
    input  wire logic  rst_n,
    scan_seq_if.ext    io,
    input  wire logic  convStarted,
    input  wire logic  trigReq,
    output logic       settled,
    output logic       muxFree,
    output logic [3:0] muxSel,
    output logic       scanDone
);
    scan_seq_pkg::host_state_t s;
    scan_seq_pkg::host_state_t n;

    always_comb begin
        n = s;

        // Reference settling hold-off
        if (!convStarted) begin
            n.settleCnt = 10'h000;
            n.settled   = 1'b0;
        end else if (s.settleCnt >= 10'(SETTLE - 1)) begin
            n.settled = 1'b1;
        end else begin
            n.settleCnt = s.settleCnt + 10'h001;
        end

        // Requests before settling are held, not lost
        if (trigReq) begin
            n.trigHold = 1'b1;
        end
        n.scanTrig = 1'b0;
        if (s.trigCnt != 2'h0) begin
            n.trigCnt  = s.trigCnt - 2'h1;
            n.scanTrig = 1'b1;
        end else if (s.trigHold && s.settled && !s.scanTrig) begin
            n.trigHold = trigReq;
            n.trigCnt  = `TRIG_HIGH - 2'h1;
            n.scanTrig = 1'b1;
        end

        // External conversion clock by divider
        if (s.divCnt >= EXT_DIV) begin
            n.divCnt = 8'h00;
            n.extClk = ~s.extClk;
        end else begin
            n.divCnt = s.divCnt + 8'h01;
        end

        // Mux may move once sampling is reported
        n.sdPrev  = io.sampleDone;
        n.scPrev  = io.scanComplete;
        n.muxFree = io.sampleDone & ~s.sdPrev;
        if (io.sampleDone && !s.sdPrev) begin
            n.muxSel = io.chanSel;
        end
        n.scanDone = io.scanComplete & ~s.scPrev;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign io.scanTrig   = s.scanTrig;
    assign io.extConvClk = s.extClk;
    assign settled       = s.settled;
    assign muxFree       = s.muxFree;
    assign muxSel        = s.muxSel;
    assign scanDone      = s.scanDone;
endmodule

`default_nettype wire

/* File: bench/scan_seq_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module scan_seq_monitor (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       scanTrig,
    input wire logic       extConvClk,
    input wire logic       sampleDone,
    input wire logic       scanComplete,
    input wire logic [3:0] chanSel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Tick is four clk internally (DIV 3) or eight (DIV 7 or external clock)
    AST_SD_WIDTH: assert property ($rose(sampleDone) |-> sampleDone[*4] ##1
        (!sampleDone or (sampleDone[*4] ##1 !sampleDone)))
        else $error("sample done width wrong");
    AST_SC_WIDTH: assert property ($rose(scanComplete) |-> scanComplete[*4] ##1
        (!scanComplete or (scanComplete[*4] ##1 !scanComplete)))
        else $error("scan complete width wrong");
    AST_SD_CHAN: assert property (sampleDone && $past(sampleDone) |-> $stable(chanSel))
        else $error("channel moved during sample done");
    AST_SC_GAP: assert property ($rose(sampleDone) |-> !scanComplete[*8])
        else $error("scan complete during conversion");
    AST_NOT_BOTH: assert property (!(sampleDone && scanComplete))
        else $error("sample done and scan complete together");
    AST_RESET_IDLE: assert property ($rose(rst_n) |-> !sampleDone && !scanComplete && chanSel == 4'h0)
        else $error("outputs not idle after reset");
    AST_TRIG_PULSE: assert property ($rose(scanTrig) |-> scanTrig[*2] ##1 !scanTrig)
        else $error("trigger pulse width wrong");
    AST_TRIG_START: assert property ($rose(scanTrig) |-> ##[1:1000] $rose(sampleDone))
        else $error("trigger started no scan");
    AST_EXT_CLK: assert property ($rose(extConvClk) |-> extConvClk[*4] ##1 !extConvClk)
        else $error("external clock half period wrong");

    cover property ($rose(scanComplete));
    cover property ($rose(sampleDone) && chanSel == 4'h8);
    cover property ($rose(scanTrig));
endmodule

`default_nettype wire

/* File: bench/test_sar_adc_scan_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scan_seq_regs.svh"

module test_sar_adc_scan_sequencer;
    typedef struct packed {
        logic [4:0]  ctrl;
        logic [8:0]  chEn;
        logic [7:0]  div;
        logic [11:0] code;
        logic        hwTrig;
    } row_t;

    logic        clk         = 1'b0;
    logic        rst_n       = 1'b0;
    logic [7:0]  regAddr     = 8'h00;
    logic [31:0] regWrData   = 32'h0;
    logic        regWrEn     = 1'b0;
    logic        regRdEn     = 1'b0;
    logic [11:0] convData    = 12'h000;
    logic        convStarted = 1'b0;
    logic        trigReq     = 1'b0;
    logic [31:0] regRdData;
    logic        irq;
    logic        settled;
    logic        muxFree;
    logic        scanDone;
    logic [3:0]  muxSel;
    logic [3:0]  seen[$];
    logic [31:0] rv;
    int          fails       = 0;
    int          num_checks  = 0;
    row_t        rows[4]     = '{'{5'h03, 9'h005, 8'h03, 12'hABC, 1'b0}, '{5'h0B, 9'h081, 8'h07, 12'h5A5, 1'b1},
                                 '{5'h13, 9'h1FF, 8'h03, 12'h3C3, 1'b1}, '{5'h07, 9'h002, 8'h03, 12'hF0F, 1'b0}};
    logic [7:0]  rstAddr[7]  = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20, 8'h80};
    logic [31:0] rstVal[7]   = '{32'h0, 32'h1, 32'h3, 32'h0, 32'h0, 32'h0, 32'h0};

    always #12.5 clk = ~clk;

    scan_seq_if u_scan_seq_if ();

    scan_seq_device u_scan_seq_device (.clk(clk), .rst_n(rst_n), .io(u_scan_seq_if.dev), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .irq(irq),
        .convData(convData));

    scan_seq_host #(.SETTLE(8)) u_scan_seq_host (.clk(clk), .rst_n(rst_n), .io(u_scan_seq_if.ext),
        .convStarted(convStarted), .trigReq(trigReq), .settled(settled), .muxFree(muxFree), .muxSel(muxSel),
        .scanDone(scanDone));

    scan_seq_monitor u_scan_seq_monitor (.clk(clk), .rst_n(rst_n), .scanTrig(u_scan_seq_if.scanTrig),
        .extConvClk(u_scan_seq_if.extConvClk), .sampleDone(u_scan_seq_if.sampleDone),
        .scanComplete(u_scan_seq_if.scanComplete), .chanSel(u_scan_seq_if.chanSel));

    task automatic summarize;
        if (fails == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1 d = regRdData;
    endtask

    task automatic trig;
        @(posedge clk);
        trigReq <= 1'b1;
        @(posedge clk);
        trigReq <= 1'b0;
    endtask

    // Records the channel of every sample done until the scan ends
    task automatic waitScan;
        int k;
        seen.delete();
        for (k = 0; k < 4000; k++) begin
            @(posedge clk);
            #1;
            if (muxFree === 1'b1) seen.push_back(muxSel);
            if (scanDone === 1'b1) break;
        end
        chk("scan finished", 32'h1, {31'h0, k < 4000});
    endtask

    task automatic countDone(input int cyc, output int n);
        n = 0;
        repeat (cyc) begin
            @(posedge clk);
            #1;
            if (scanDone === 1'b1) n++;
        end
    endtask

    initial begin
        int n;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        convStarted <= 1'b1;
        repeat (12) @(posedge clk);
        chk("settled", 32'h1, {31'h0, settled});
        wr(`MASK_OFS, 32'h1);
        foreach (rows[i]) begin
            convData <= rows[i].code;
            // Divisors give 10 or 5 MHz; bypassed reference assumed above 3 MHz
            wr(`DIV_OFS, {24'h0, rows[i].div});
            wr(`CHEN_OFS, {23'h0, rows[i].chEn});
            wr(`CTRL_OFS, {27'h0, rows[i].ctrl});
            if (rows[i].hwTrig) trig();
            else wr(`CMD_OFS, 32'h1);
            waitScan();
            n = 0;
            for (int c = 0; c < 9; c++) begin
                if (rows[i].chEn[c]) begin
                    chk("mux order", c, {28'h0, seen[n]});
                    rd(8'(`RES_OFS + 4 * c), rv);
                    chk("result", {20'h0, rows[i].code >> (2 * rows[i].ctrl[4:3])}, rv);
                    n++;
                end
            end
            chk("channel count", n, seen.size());
            rd(`CHEN_OFS, rv);
            chk("injection one shot", {23'h0, rows[i].chEn & 9'h0FF}, rv);
            rd(`STAT_OFS, rv);
            chk("status", 32'h1, rv & 32'h1);
            chk("irq", 32'h1, {31'h0, irq});
            wr(`STAT_OFS, 32'h1);
            rd(`STAT_OFS, rv);
            chk("status clear", 32'h0, rv & 32'h1);
            chk("irq clear", 32'h0, {31'h0, irq});
        end
        // Masked event still sets status, irq follows the mask
        wr(`MASK_OFS, 32'h0);
        wr(`CTRL_OFS, 32'h03);
        wr(`CMD_OFS, 32'h1);
        countDone(400, n);
        chk("command scans", 32'h1, n);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`MASK_OFS, 32'h1);
        rd(`MASK_OFS, rv);
        chk("mask", 32'h1, rv);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        @(posedge clk);
        #1 chk("read data one cycle", 32'h0, regRdData);
        wr(`STAT_OFS, 32'h1);
        // Second trigger during a busy scan is remembered
        trig();
        repeat (16) @(posedge clk);
        rd(`STAT_OFS, rv);
        chk("busy", 32'h2, rv);
        trig();
        countDone(600, n);
        chk("pending trigger", 32'h2, n);
        wr(`CTRL_OFS, 32'h01);
        countDone(400, n);
        chk("free running", 32'h1, {31'h0, n > 2});
        wr(`CMD_OFS, 32'h2);
        countDone(200, n);
        rd(`CTRL_OFS, rv);
        chk("stop clears enable", 32'h0, rv & 32'h1);
        countDone(400, n);
        chk("stopped", 32'h0, n);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rstAddr[j]) begin
            rd(rstAddr[j], rv);
            chk("reset value", rstVal[j], rv);
        end
        chk("irq after reset", 32'h0, {31'h0, irq});
        // Restarting the converter restarts the settling hold-off
        @(posedge clk);
        convStarted <= 1'b0;
        wr(`CTRL_OFS, 32'h03);
        convStarted <= 1'b1;
        trig();
        @(posedge clk);
        #1 chk("trigger held off", 32'h0, {31'h0, u_scan_seq_if.scanTrig});
        repeat (7) @(posedge clk);
        #1 chk("trigger after settling", 32'h1, {31'h0, u_scan_seq_if.scanTrig});
        waitScan();
        summarize();
    end

    // Whole run needs well under ten thousand cycles
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        summarize();
    end
endmodule

`default_nettype wire
